// ---- design/timer_two_reload_capture.sv ----
// 16-bit timer/counter with prescaler, reload/capture and output pin
// assumes sfr_* bus synchronous to clk; reads return data one cycle later
`timescale 1ns/10ps
`default_nettype none
module timer_two_reload_capture
    import timer_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output var  logic [7:0] sfr_rdata,
    input  wire logic       timer_int_enable,
    input  wire logic       neighbour_overflow,
    input  wire logic       count_input_pin,
    input  wire logic       trigger_pin,
    output var  logic       timer_irq,
    output var  logic       timer_out,
    output var  logic       timer_out_oe
);
    logic rst_a_q;
    logic rst_n_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_a_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_n_q <= rst_a_q;
        end
    end

    edge_if count_e ();
    edge_if trig_e ();
    assign count_e.pin = count_input_pin;
    assign trig_e.pin  = trigger_pin;
    fall_detect u_count (.clk(clk), .rst_n(rst_n_q), .e(count_e));
    fall_detect u_trig  (.clk(clk), .rst_n(rst_n_q), .e(trig_e));

    // one counter register pair; no 8-bit split exists
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] reload_q;
    logic [15:0] reload_d;
    logic [7:0]  ctrl_q;
    logic [7:0]  ctrl_d;
    logic [7:0]  ccfg_q;
    logic [13:0] pre_q;
    logic        swreq_q;
    logic        irq_q;
    logic        out_q;
    logic        oe_q;
    logic [7:0]  rdata_q;

    function automatic logic [13:0] prescale_mask(input logic [3:0] f);
        logic [3:0] e;
        e = (f > PRESCALE_MAX) ? PRESCALE_MAX : f;
        prescale_mask = 14'((15'h0001 << e) - 15'h0001);
    endfunction : prescale_mask

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target, input logic w);
        wr_hit = w && (a == target);
    endfunction : wr_hit

    wire        run         = ctrl_q[BIT_RUN];
    wire        down        = ctrl_q[BIT_COUNT_DOWN];
    wire        trig_en     = ctrl_q[BIT_TRIGGER_ENABLE];
    wire        cap_sel     = ctrl_q[BIT_CAPTURE_SELECT];
    wire        toggle_mode = ctrl_q[BIT_TOGGLE_MODE];
    wire [13:0] pmask       = prescale_mask(ccfg_q[3:0]);
    wire        pre_tick    = (pre_q & pmask) == pmask;

    tick_source_t src;
    assign src = ctrl_q[BIT_EVENT_COUNTER] ? SRC_COUNT_PIN
               : ccfg_q[BIT_CLOCK_SOURCE] ? SRC_NEIGHBOUR
               : SRC_PRESCALER;

    logic tick;
    always_comb begin
        case (src)
            SRC_PRESCALER: tick = pre_tick;
            SRC_NEIGHBOUR: tick = neighbour_overflow;
            SRC_COUNT_PIN: tick = count_e.fall;
            default:       tick = 1'b0;
        endcase
    end

    wire step      = run && tick;
    wire wrap_up   = !down && (count_q == COUNT_ALL_ONES);
    wire wrap_down = down && (count_q == COUNT_ZERO);
    wire overflow  = step && (wrap_up || wrap_down);
    wire trig_act  = trig_en && trig_e.fall;
    wire do_reload = trig_act && !cap_sel;
    wire do_capt   = trig_act && cap_sel;

    wire w_cl  = wr_hit(sfr_addr, ADDR_COUNT_LOW, sfr_wr);
    wire w_ch  = wr_hit(sfr_addr, ADDR_COUNT_HIGH, sfr_wr);
    wire w_rl  = wr_hit(sfr_addr, ADDR_RELOAD_LOW, sfr_wr);
    wire w_rh  = wr_hit(sfr_addr, ADDR_RELOAD_HIGH, sfr_wr);
    wire w_ctl = wr_hit(sfr_addr, ADDR_CONTROL, sfr_wr);
    wire w_cfg = wr_hit(sfr_addr, ADDR_CLOCK_CFG, sfr_wr);

    // reload beats stepping; software write to a byte beats both
    always_comb begin
        count_d = count_q;
        if (do_reload)
            count_d = reload_q;
        else if (step)
            count_d = down ? count_q - 16'h0001 : count_q + 16'h0001;
        if (w_cl)
            count_d[7:0] = sfr_wdata;
        if (w_ch)
            count_d[15:8] = sfr_wdata;
    end

    always_comb begin
        reload_d = reload_q;
        if (w_rl)
            reload_d[7:0] = sfr_wdata;
        if (w_rh)
            reload_d[15:8] = sfr_wdata;
        if (do_capt)
            reload_d = count_q;
    end

    // hardware set wins over a software clear in the same cycle
    always_comb begin
        ctrl_d = w_ctl ? sfr_wdata : ctrl_q;
        if (overflow)
            ctrl_d[BIT_OVERFLOW_FLAG] = 1'b1;
        if (trig_act)
            ctrl_d[BIT_EXTERNAL_FLAG] = 1'b1;
    end

    wire sw_ovf_write = w_ctl && sfr_wdata[BIT_OVERFLOW_FLAG];
    wire irq_d = timer_int_enable && (ctrl_d[BIT_OVERFLOW_FLAG] || sw_ovf_write || swreq_q);
    wire out_d = toggle_mode ? (out_q ^ overflow) : overflow;

    logic [7:0] rmux;
    always_comb begin
        case (sfr_addr)
            ADDR_COUNT_LOW:   rmux = count_q[7:0];
            ADDR_COUNT_HIGH:  rmux = count_q[15:8];
            ADDR_RELOAD_LOW:  rmux = reload_q[7:0];
            ADDR_RELOAD_HIGH: rmux = reload_q[15:8];
            ADDR_CONTROL:     rmux = ctrl_q;
            ADDR_CLOCK_CFG:   rmux = ccfg_q;
            default:          rmux = RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            count_q  <= COUNT_ZERO;
            reload_q <= COUNT_ZERO;
            ctrl_q   <= RESET_BYTE;
            ccfg_q   <= RESET_BYTE;
        end else begin
            count_q  <= count_d;
            reload_q <= reload_d;
            ctrl_q   <= ctrl_d;
            if (w_cfg)
                ccfg_q <= sfr_wdata & CLOCK_CFG_MASK;
        end
    end

    // prescaler free-runs; a new field value takes effect at the next aligned boundary
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pre_q <= 14'h0000;
        end else begin
            pre_q <= pre_q + 14'h0001;
        end
    end

    // software-written overflow request holds one extra cycle so a pulse is seen
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            swreq_q <= 1'b0;
            irq_q   <= 1'b0;
            out_q   <= 1'b0;
            oe_q    <= 1'b0;
            rdata_q <= RESET_BYTE;
        end else begin
            swreq_q <= sw_ovf_write;
            irq_q   <= irq_d;
            out_q   <= out_d;
            oe_q    <= ccfg_q[BIT_OUTPUT_ENABLE];
            if (sfr_rd)
                rdata_q <= rmux;
        end
    end

    assign sfr_rdata    = rdata_q;
    assign timer_irq    = irq_q;
    assign timer_out    = out_q;
    assign timer_out_oe = oe_q;
endmodule : timer_two_reload_capture
`default_nettype wire

// ---- inc/timer_pkg.sv ----
// constants, register map and field layout of the 16-bit reload/capture timer
// assumes an 8-bit special-function-register bus with byte addresses
// How it works
// - rollover up sets sticky overflow flag
// - software writing one to overflow requests interrupt
// - interrupt asserted while overflow flag and enable
// - trigger falling edge sets external flag when enabled
// - direction bit zero counts up, one down
// - down rollover zero to all-ones sets overflow
// - event counter mode counts count-pin edges
// - each count-pin falling edge steps counter once
// - clock source bit picks neighbour overflow
// - prescaler divides by two to field, capped
// - trigger pin ignored unless trigger enable set
// - capture select zero: trigger reloads counter
// - capture select one: trigger captures counter
// - counter advances only while run bit set
// - output enable drives pin, else deactivated
// - pulse mode: one-clock pulse per overflow
// - toggle mode: output inverts on overflow
// - always one 16-bit counter, no split
package timer_pkg;
    localparam logic [7:0] ADDR_COUNT_LOW   = 8'h8E;
    localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h8F;
    localparam logic [7:0] ADDR_RELOAD_LOW  = 8'h96;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h97;
    localparam logic [7:0] ADDR_CONTROL     = 8'h9C;
    localparam logic [7:0] ADDR_CLOCK_CFG   = 8'h9D;
    localparam logic [7:0] RESET_BYTE       = 8'h00;
    localparam int BIT_OVERFLOW_FLAG    = 7;
    localparam int BIT_EXTERNAL_FLAG    = 6;
    localparam int BIT_COUNT_DOWN       = 5;
    localparam int BIT_TOGGLE_MODE      = 4;
    localparam int BIT_TRIGGER_ENABLE   = 3;
    localparam int BIT_RUN              = 2;
    localparam int BIT_EVENT_COUNTER    = 1;
    localparam int BIT_CAPTURE_SELECT   = 0;
    localparam int BIT_CLOCK_SOURCE     = 5;
    localparam int BIT_OUTPUT_ENABLE    = 4;
    localparam logic [7:0] CLOCK_CFG_MASK = 8'h3F;
    localparam logic [3:0] PRESCALE_MAX   = 4'hE;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO     = 16'h0000;
    typedef enum logic [1:0] {
        SRC_PRESCALER = 2'b00,
        SRC_NEIGHBOUR = 2'b01,
        SRC_COUNT_PIN = 2'b10
    } tick_source_t;
endpackage : timer_pkg

// ---- inc/edge_if.sv ----
// carries a falling-edge detector's pin sample and event pulse
// assumes one clock domain shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface edge_if;
    logic pin;
    logic fall;
    modport detector (input pin, output fall);
    modport user     (output pin, input fall);
endinterface : edge_if
`default_nettype wire

// ---- design/fall_detect.sv ----
// synchroniser and falling-edge detector for one pin
// assumes pins asynchronous to clk may arrive; reset is the synchronised copy
`timescale 1ns/10ps
`default_nettype none
module fall_detect (
    input  wire logic clk,
    input  wire logic rst_n,
    edge_if.detector  e
);
    logic meta_q;
    logic sync_q;
    logic last_q;
    logic fall_q;
    wire  fall_d = last_q & ~sync_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
            fall_q <= 1'b0;
        end else begin
            meta_q <= e.pin;
            sync_q <= meta_q;
            last_q <= sync_q;
            fall_q <= fall_d;
        end
    end
    assign e.fall = fall_q;
endmodule : fall_detect
`default_nettype wire

// ---- tb/pin_model.sv ----
// far-side pins: count pin, trigger pin, neighbour overflow
// assumes the bench calls the tasks; count and trigger pins idle high, neighbour overflow idles low between events
`timescale 1ns/10ps
`default_nettype none
module pin_model (
    input  wire logic clk,
    output var  logic count_pin,
    output var  logic trig_pin,
    output var  logic nb_ovf
);
    initial begin
        count_pin = 1'h1;
        trig_pin  = 1'h1;
        nb_ovf    = 1'h0;
    end
    // low for four cycles so the two-flop synchroniser cannot miss it
    task automatic fall(input bit trig);
        @(posedge clk) #1 if (trig) trig_pin = 1'h0; else count_pin = 1'h0;
        repeat (4) @(posedge clk);
        #1 if (trig) trig_pin = 1'h1; else count_pin = 1'h1;
        repeat (4) @(posedge clk);
    endtask : fall
    task automatic nb_tick();
        @(posedge clk) #1 nb_ovf = 1'h1;
        @(posedge clk) #1 nb_ovf = 1'h0;
    endtask : nb_tick
endmodule : pin_model
`default_nettype wire

// ---- tb/timer_chk.sv ----
// port-level assertions for the reload/capture timer
// assumes bound to timer_two_reload_capture, one clock domain
`timescale 1ns/10ps
`default_nettype none
module timer_chk (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       timer_int_enable,
    input wire logic       timer_irq,
    input wire logic       timer_out,
    input wire logic       timer_out_oe
);
    logic tog_q;
    // mirror of the toggle-mode bit, seen only through bus writes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) tog_q <= 1'h0;
        else if (sfr_wr && sfr_addr == 8'h9C) tog_q <= sfr_wdata[4];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_RST_QUIET: assert property ($rose(resetn) |-> (!timer_irq && !timer_out && !timer_out_oe) [*2])
        else $error("outputs active after reset");
    AST_SW_IRQ: assert property (sfr_wr && sfr_addr == 8'h9C && sfr_wdata[7] && timer_int_enable |-> ##[1:3] timer_irq)
        else $error("no irq after flag write");
    AST_IRQ_GATE: assert property (timer_irq |-> $past(timer_int_enable))
        else $error("irq while disabled");
    AST_OE_SET: assert property (sfr_wr && sfr_addr == 8'h9D |-> ##2 timer_out_oe == $past(sfr_wdata[4], 2))
        else $error("output enable mismatch");
    AST_PULSE_ONE: assert property (!tog_q && $rose(timer_out) |=> !timer_out)
        else $error("pulse longer than one cycle");
    AST_TOGGLE_HOLD: assert property (tog_q && $rose(timer_out) |=> timer_out [*2])
        else $error("toggle level not held");
    AST_UNMAPPED: assert property (sfr_rd && !(sfr_addr inside {8'h8E, 8'h8F, 8'h96, 8'h97, 8'h9C, 8'h9D})
        |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RELOAD_RW: assert property ((sfr_wr && sfr_addr == 8'h96) ##2 (sfr_rd && sfr_addr == 8'h96)
        |=> sfr_rdata == $past(sfr_wdata, 3))
        else $error("reload byte readback");
endmodule : timer_chk
bind timer_two_reload_capture timer_chk u_chk (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .timer_int_enable(timer_int_enable), .timer_irq(timer_irq), .timer_out(timer_out),
    .timer_out_oe(timer_out_oe));
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the 16-bit reload/capture timer
// assumes pin_model drives the far-side pins
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_q;
    logic       clk, resetn, sfr_wr, sfr_rd, int_en, cnt_pin, trig_pin, nb_ovf;
    logic       timer_irq, timer_out, timer_out_oe;
    int         n_mismatch = 0, tests_run = 0, cycles = 0, n_high = 0, h0;
    logic [7:0] addrs [7] = '{8'h8E, 8'h8F, 8'h96, 8'h97, 8'h9C, 8'h9D, 8'h9E};
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    timer_two_reload_capture DUT (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_int_enable(int_en),
        .neighbour_overflow(nb_ovf), .count_input_pin(cnt_pin), .trigger_pin(trig_pin),
        .timer_irq(timer_irq), .timer_out(timer_out), .timer_out_oe(timer_out_oe));
    pin_model pins (.clk(clk), .count_pin(cnt_pin), .trig_pin(trig_pin), .nb_ovf(nb_ovf));
    // longest test is the capped prescaler window, about 57k cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (timer_out === 1'h1) n_high <= n_high + 1;
        if (cycles == 80000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1 {sfr_wr, sfr_addr, sfr_wdata} = {1'h1, a, d};
        @(posedge clk) #1 sfr_wr = 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk) #1 {sfr_rd, sfr_addr} = {1'h1, a};
        @(posedge clk) #1 sfr_rd = 1'h0;
        rd_q = sfr_rdata;
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk($sformatf("reg %h", a), 16'(rd_q), 16'(e));
    endtask : rdc
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        {resetn, sfr_wr, sfr_rd, int_en, sfr_addr, sfr_wdata} = '0;
        repeat (12) @(posedge clk);
        #1 resetn = 1'h1;
        repeat (3) @(posedge clk);
        wr(8'h9E, 8'hFF);
        foreach (addrs[i]) rdc(addrs[i], 8'h00);
        done("reset");
        wr(8'h96, 8'hA5);
        rdc(8'h96, 8'hA5);
        wr(8'h97, 8'h5A);
        rdc(8'h97, 8'h5A);
        wr(8'h9D, 8'hFF);
        rdc(8'h9D, 8'h3F);
        chk("oe", 16'(timer_out_oe), 16'h0001);
        done("registers");
        int_en = 1'h1;
        wr(8'h8E, 8'hFE);
        wr(8'h8F, 8'hFF);
        wr(8'h9D, 8'h30);
        wr(8'h9C, 8'h04);
        h0 = n_high;
        repeat (2) pins.nb_tick();
        repeat (4) @(posedge clk);
        rdc(8'h9C, 8'h84);
        rdc(8'h8E, 8'h00);
        chk("irq", 16'(timer_irq), 16'h0001);
        chk("pulses", 16'(n_high - h0), 16'h0001);
        wr(8'h9C, 8'h00);
        pins.nb_tick();
        rdc(8'h8E, 8'h00);
        chk("irq", 16'(timer_irq), 16'h0000);
        wr(8'h9C, 8'h80);
        chk("irq", 16'(timer_irq), 16'h0001);
        done("count up");
        wr(8'h9C, 8'h24);
        pins.nb_tick();
        rdc(8'h8F, 8'hFF);
        rdc(8'h9C, 8'hA4);
        // neighbour tick must be ignored once event mode is on
        wr(8'h9C, 8'h06);
        repeat (2) pins.fall(1'h0);
        pins.nb_tick();
        rdc(8'h8E, 8'h01);
        rdc(8'h9C, 8'h86);
        done("down and event");
        wr(8'h96, 8'h34);
        wr(8'h97, 8'h12);
        wr(8'h9C, 8'h02);
        pins.fall(1'h1);
        rdc(8'h9C, 8'h02);
        rdc(8'h8E, 8'h01);
        wr(8'h9C, 8'h08);
        pins.fall(1'h1);
        rdc(8'h8E, 8'h34);
        rdc(8'h8F, 8'h12);
        rdc(8'h9C, 8'h48);
        wr(8'h8E, 8'hCD);
        wr(8'h8F, 8'hAB);
        wr(8'h9C, 8'h09);
        pins.fall(1'h1);
        rdc(8'h96, 8'hCD);
        rdc(8'h97, 8'hAB);
        done("trigger");
        // free-running prescaler: the window phase allows one tick of slack
        for (int i = 0; i < 2; i++) begin
            wr(8'h9D, i ? 8'h0F : 8'h02);
            wr(8'h8E, 8'h00);
            wr(8'h8F, 8'h00);
            wr(8'h9C, 8'h04);
            repeat (i ? 57344 : 40) @(posedge clk);
            wr(8'h9C, 8'h00);
            rd(8'h8E);
            chk("prescale", 16'(rd_q inside {[(i ? 3 : 9):(i ? 4 : 12)]}), 16'h0001);
        end
        done("prescaler");
        wr(8'h9D, 8'h30);
        for (int i = 0; i < 2; i++) begin
            wr(8'h8E, 8'hFF);
            wr(8'h8F, 8'hFF);
            wr(8'h9C, 8'h14);
            pins.nb_tick();
            repeat (3) @(posedge clk);
            chk("toggle", 16'(timer_out), 16'(i == 0));
        end
        done("toggle");
        final_report();
    end
endmodule : testbench
`default_nettype wire
